// ==== bdvc_map.vh ====
// Register map, field positions, reset values and timing constants for the buck voltage-control block.
// Assumes a 32-bit APB slave with one register per aligned word.
`ifndef BDVC_MAP_VH
`define BDVC_MAP_VH

// Register byte offsets.
`define BDVC_OFF_CTRL       12'h000
`define BDVC_OFF_SELG1      12'h004
`define BDVC_OFF_SELG2      12'h008
`define BDVC_OFF_STATUS     12'h00C
`define BDVC_OFF_SEQ        12'h010
`define BDVC_OFF_RAIL0      12'h020
`define BDVC_RAIL_STRIDE    12'h020
`define BDVC_SUB_CFG        12'h000
`define BDVC_SUB_VFIRST     12'h004
`define BDVC_SUB_VSECOND    12'h008
`define BDVC_SUB_LEVEL      12'h00C

// Global control fields.
`define BDVC_CTRL_SLEW_LO   0
`define BDVC_CTRL_SOFT      2
`define BDVC_CTRL_FBRDY     3
`define BDVC_CTRL_DEFLOAD   4

// Per-rail configuration fields.
`define BDVC_CFG_EN         0
`define BDVC_CFG_MODE_LO    1
`define BDVC_CFG_KEEP       3
`define BDVC_CFG_PDOFF      4
`define BDVC_CFG_DEFPICK    5
`define BDVC_CFG_ENPIN_LO   6
`define BDVC_CFG_VPIN_LO    8
`define BDVC_CFG_SLOT_LO    10

// Sequencer command field values.
`define BDVC_SEQ_UP         2'h1
`define BDVC_SEQ_DOWN       2'h2
`define BDVC_SEQ_RESET      2'h3

// Operating modes.
`define BDVC_MODE_AUTO      2'h0
`define BDVC_MODE_PWM       2'h1
`define BDVC_MODE_PFM       2'h2

// Voltage codes are 10 mV per step; code 0 is the lowest setting.
`define BDVC_VCODE_FLOOR    8'h28
`define BDVC_VFIRST_RST     8'h46

// Timing.
`define BDVC_CLK_MHZ        125
`define BDVC_SOFT_US        3000
`define BDVC_STEP_NS_MIN    500

`endif

// ==== bdvc_buck_dvc_control.v ====
// Digital voltage control for six step-down rails: ramps, mode, sequencer, pin control.
// Assumes an APB master on clk_in and synchronous input pins; analog side reads the outputs.
`timescale 1ns/1ns
`include "bdvc_map.vh"

module bdvc_buck_dvc_control #(
    parameter NRAIL     = 6,
    parameter SOFT_CYC  = (`BDVC_SOFT_US * `BDVC_CLK_MHZ),
    parameter [7:0] DEF_VFIRST = `BDVC_VFIRST_RST
) (
    // Clock and reset.
    input  wire              clk_in,
    input  wire              rst_in,
    // APB slave.
    input  wire              psel_in,
    input  wire              penable_in,
    input  wire              pwrite_in,
    input  wire [11:0]       paddr_in,
    input  wire [31:0]       pwdata_in,
    output reg  [31:0]       prdata_out,
    output reg               pready_out,
    output reg               pslverr_out,
    // General-purpose inputs one, two and thirteen.
    input  wire [2:0]        gpi_in,
    // Sequencer slot stream: command and slot id, one-cycle strobe.
    input  wire              seq_stb_in,
    input  wire [1:0]        seq_cmd_in,
    input  wire [3:0]        seq_slot_in,
    input  wire              seq_wake_in,
    // Rail controls to the analog converters.
    output reg  [NRAIL-1:0]  rail_en_out,
    output reg  [NRAIL-1:0]  rail_pfm_out,
    output reg  [NRAIL-1:0]  rail_auto_out,
    output reg  [NRAIL-1:0]  rail_ilim_out,
    output reg  [NRAIL-1:0]  rail_pulldown_out,
    output reg  [8*NRAIL-1:0] rail_vcode_out,
    output reg               feedback_port_one_out,
    output reg               slew_done_event_out
);
    localparam [31:0] STEP_CYC = (`BDVC_STEP_NS_MIN * `BDVC_CLK_MHZ) / 1000;

    // Global control and event state.
    reg  [31:0]       ctrl_q;
    reg  [2:0]        gpi_q;
    reg  [2:0]        edge_flag_q;
    reg               any_slew_q;
    reg  [31:0]       tick_cnt_q;
    reg               tick_q;

    // Held register write, replayed after a pin update.
    reg               hold_v_q;
    reg  [11:0]       hold_a_q;
    reg  [31:0]       hold_d_q;

    wire              wr_acc = psel_in & penable_in & pwrite_in;
    wire [2:0]        gpi_edge = gpi_in ^ gpi_q;
    wire              pin_evt = |gpi_edge;
    wire              do_wr = (wr_acc & ~pin_evt) | (hold_v_q & ~pin_evt);
    wire [11:0]       wa = hold_v_q ? hold_a_q : paddr_in;
    wire [31:0]       wd = hold_v_q ? hold_d_q : pwdata_in;
    wire [NRAIL-1:0]  slewing;
    wire [31:0]       step_div = STEP_CYC << (3 - ctrl_q[`BDVC_CTRL_SLEW_LO +: 2]);

    // Per-rail state.
    reg  [15:0]       cfg_q   [0:NRAIL-1];
    reg  [7:0]        vfst_q  [0:NRAIL-1];
    reg  [7:0]        vsec_q  [0:NRAIL-1];
    reg  [7:0]        cur_q   [0:NRAIL-1];
    reg  [NRAIL-1:0]  sel_q;
    reg  [NRAIL-1:0]  en_q;
    reg  [31:0]       soft_q  [0:NRAIL-1];

    // Slew tick shared by all rails, so every trigger source ramps alike.
    always @(posedge clk_in) begin
        if (rst_in) begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q + 32'h1 >= step_div) begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
            tick_q <= 1'b0;
        end
    end

    // Global control, pin sampling, held write and ready tracking.
    always @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_q <= 32'h0;
            gpi_q <= 3'h0;
            edge_flag_q <= 3'h0;
            hold_v_q <= 1'b0;
            hold_a_q <= 12'h000;
            hold_d_q <= 32'h0;
            any_slew_q <= 1'b0;
            feedback_port_one_out <= 1'b0;
            slew_done_event_out <= 1'b0;
        end else begin
            gpi_q <= gpi_in;
            // Edge flags are cleared every cycle and never read; the rail update uses gpi_edge in the same cycle.
            edge_flag_q <= 3'h0;
            // A write that meets a pin edge is parked, then replayed to override.
            if (wr_acc & pin_evt) begin
                hold_v_q <= 1'b1;
                hold_a_q <= paddr_in;
                hold_d_q <= pwdata_in;
            end else if (hold_v_q & ~pin_evt) begin
                hold_v_q <= 1'b0;
            end
            if (do_wr && wa == `BDVC_OFF_CTRL)
                ctrl_q <= wd;
            any_slew_q <= |slewing;
            feedback_port_one_out <= ctrl_q[`BDVC_CTRL_FBRDY] & (|slewing);
            slew_done_event_out <= ctrl_q[`BDVC_CTRL_FBRDY] & any_slew_q & ~(|slewing);
        end
    end

    // APB slave: zero wait states; an unmapped address answers with an error.
    wire [11:0] rsub = paddr_in - `BDVC_OFF_RAIL0;
    wire [2:0]  ridx = rsub[7:5];
    // The upper offset bits must be zero too, or high addresses would alias rail zero.
    wire        rmap = (paddr_in >= `BDVC_OFF_RAIL0) && (ridx < NRAIL) && (rsub[4] == 1'b0)
                       && (rsub[11:8] == 4'h0);
    wire        gmap = (paddr_in <= `BDVC_OFF_SEQ);
    always @(posedge clk_in) begin
        if (rst_in) begin
            prdata_out <= 32'h0;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= psel_in & ~penable_in;
            pslverr_out <= psel_in & ~penable_in & ~(rmap | gmap);
            prdata_out <= 32'h0;
            if (psel_in & ~penable_in & ~pwrite_in) begin
                case (paddr_in)
                    `BDVC_OFF_CTRL:   prdata_out <= ctrl_q;
                    // Reads give the live enable and select state.
                    `BDVC_OFF_SELG1:  prdata_out <= {26'h0, en_q};
                    `BDVC_OFF_SELG2:  prdata_out <= {26'h0, sel_q};
                    `BDVC_OFF_STATUS: prdata_out <= {26'h0, slewing};
                    default: begin
                        if (rmap) begin
                            case (rsub[3:0])
                                4'h0:    prdata_out <= {16'h0, cfg_q[ridx][15:1], en_q[ridx]};
                                4'h4:    prdata_out <= {24'h0, vfst_q[ridx]};
                                4'h8:    prdata_out <= {24'h0, vsec_q[ridx]};
                                default: prdata_out <= {24'h0, cur_q[ridx]};
                            endcase
                        end
                    end
                endcase
            end
        end
    end
    genvar g;
    generate
        for (g = 0; g < NRAIL; g = g + 1) begin : g_rail
            wire [31:0] base_w = `BDVC_OFF_RAIL0 + g * `BDVC_RAIL_STRIDE;
            wire [11:0] base = base_w[11:0];
            wire [1:0]  enpin = cfg_q[g][`BDVC_CFG_ENPIN_LO +: 2];
            wire [1:0]  vpin = cfg_q[g][`BDVC_CFG_VPIN_LO +: 2];
            wire        en_pinctl = (enpin != 2'h0);
            wire        v_pinctl = (vpin != 2'h0);
            wire        en_hit = en_pinctl && gpi_edge[enpin - 2'h1];
            wire        v_hit = v_pinctl && gpi_edge[vpin - 2'h1];
            wire        slot_hit = seq_stb_in && (cfg_q[g][`BDVC_CFG_SLOT_LO +: 4] == seq_slot_in);
            wire [7:0]  tgt_raw = sel_q[g] ? vsec_q[g] : vfst_q[g];
            // Floor clamp: below it the rail sits at floor in PFM.
            wire        low_tgt = tgt_raw < `BDVC_VCODE_FLOOR;
            wire [7:0]  tgt = low_tgt ? `BDVC_VCODE_FLOOR : tgt_raw;
            assign slewing[g] = en_q[g] && (cur_q[g] != tgt);

            always @(posedge clk_in) begin
                if (rst_in) begin
                    cfg_q[g] <= 16'h0;
                    vfst_q[g] <= DEF_VFIRST;
                    vsec_q[g] <= DEF_VFIRST;
                    cur_q[g] <= 8'h0;
                    sel_q[g] <= 1'b0;
                    en_q[g] <= 1'b0;
                    soft_q[g] <= 32'h0;
                    rail_en_out[g] <= 1'b0;
                    rail_pfm_out[g] <= 1'b0;
                    rail_auto_out[g] <= 1'b0;
                    rail_ilim_out[g] <= 1'b0;
                    rail_pulldown_out[g] <= 1'b1;
                    rail_vcode_out[8*g +: 8] <= 8'h0;
                end else begin
                    // Host writes: voltage codes, config, and group select registers.
                    if (do_wr) begin
                        if (wa == base + `BDVC_SUB_CFG) begin
                            cfg_q[g] <= wd[15:0];
                            en_q[g] <= wd[`BDVC_CFG_EN];
                        end
                        // Ramp follows from tgt; only the selected register moves it.
                        if (wa == base + `BDVC_SUB_VFIRST)
                            vfst_q[g] <= wd[7:0];
                        if (wa == base + `BDVC_SUB_VSECOND)
                            vsec_q[g] <= wd[7:0];
                        if (wa == `BDVC_OFF_SELG1)
                            en_q[g] <= wd[g];
                        if (wa == `BDVC_OFF_SELG2)
                            sel_q[g] <= wd[g];
                    end
                    // Pin edge applies the pin level to assigned rails.
                    if (en_hit)
                        en_q[g] <= gpi_in[enpin - 2'h1];
                    if (v_hit)
                        sel_q[g] <= gpi_in[vpin - 2'h1];
                    // Sequencer actions, skipping pin-owned settings except on reset, which clears every enable.
                    if (seq_stb_in && seq_cmd_in == `BDVC_SEQ_RESET) begin
                        en_q[g] <= 1'b0;
                    end else if (slot_hit && seq_cmd_in == `BDVC_SEQ_UP) begin
                        if (seq_slot_in == 4'h0 && !ctrl_q[`BDVC_CTRL_DEFLOAD]) begin
                            if (!en_pinctl)
                                en_q[g] <= 1'b0;
                        end else begin
                            if (seq_slot_in == 4'h0 && cfg_q[g][`BDVC_CFG_DEFPICK])
                                vfst_q[g] <= DEF_VFIRST;
                            if (!en_pinctl)
                                en_q[g] <= 1'b1;
                            if (!v_pinctl)
                                sel_q[g] <= 1'b0;
                        end
                        if (seq_wake_in)
                            vfst_q[g] <= DEF_VFIRST;
                    end else if (slot_hit && seq_cmd_in == `BDVC_SEQ_DOWN) begin
                        if (cfg_q[g][`BDVC_CFG_KEEP]) begin
                            if (!v_pinctl)
                                sel_q[g] <= 1'b1;
                        end else if (!en_pinctl) begin
                            en_q[g] <= 1'b0;
                        end
                    end
                    // Stepped ramp toward the target at the shared rate.
                    if (!en_q[g])
                        cur_q[g] <= tgt;
                    else if (tick_q && cur_q[g] < tgt)
                        cur_q[g] <= cur_q[g] + 8'h1;
                    else if (tick_q && cur_q[g] > tgt)
                        cur_q[g] <= cur_q[g] - 8'h1;
                    // Soft-start window after each enable.
                    if (!en_q[g])
                        soft_q[g] <= 32'h0;
                    else if (soft_q[g] < SOFT_CYC)
                        soft_q[g] <= soft_q[g] + 32'h1;
                    rail_en_out[g] <= en_q[g];
                    rail_ilim_out[g] <= en_q[g] & ctrl_q[`BDVC_CTRL_SOFT] & (soft_q[g] < SOFT_CYC);
                    // Mode select with forced PFM at the floor.
                    rail_pfm_out[g] <= (cfg_q[g][`BDVC_CFG_MODE_LO +: 2] == `BDVC_MODE_PFM) |
                                       (low_tgt & (cur_q[g] == tgt));
                    rail_auto_out[g] <= (cfg_q[g][`BDVC_CFG_MODE_LO +: 2] == `BDVC_MODE_AUTO);
                    rail_pulldown_out[g] <= ~en_q[g] & ~cfg_q[g][`BDVC_CFG_PDOFF];
                    rail_vcode_out[8*g +: 8] <= (low_tgt && cur_q[g] == tgt) ? tgt_raw : cur_q[g];
                end
            end
        end
    endgenerate
endmodule

// ==== bdvc_host.sv ====
// Host processor model: an APB master that runs one transfer per call.
// Assumes a clock shared with the slave; the bench calls xfer and then reads rd_q and err_q.
`timescale 1ns/1ns
module bdvc_host (
    // Clock.
    input  wire        clk_in,
    // APB master side.
    output reg         psel_out,
    output reg         penable_out,
    output reg         pwrite_out,
    output reg  [11:0] paddr_out,
    output reg  [31:0] pwdata_out,
    input  wire [31:0] prdata_in,
    input  wire        pready_in,
    input  wire        pslverr_in
);
    reg [31:0] rd_q;
    reg        err_q;
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 12'h000;
        pwdata_out = 32'h0000_0000;
    end
    task xfer(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge clk_in);
            psel_out <= 1'b1;
            penable_out <= 1'b0;
            pwrite_out <= w;
            paddr_out <= a;
            pwdata_out <= d;
            @(posedge clk_in);
            penable_out <= 1'b1;
            do @(posedge clk_in); while (pready_in !== 1'b1);
            rd_q = prdata_in;
            err_q = pslverr_in;
            psel_out <= 1'b0;
            penable_out <= 1'b0;
            // Released data is inverted so a stale word never passes for fresh data.
            pwdata_out <= ~d;
        end
    endtask
endmodule

// ==== bdvc_chk_sva.sv ====
// Port-level checker for the buck voltage-control block.
// Assumes it is bound into the design module and sees its ports only.
`timescale 1ns/1ns
`include "bdvc_map.vh"
module bdvc_chk #(
    parameter NRAIL = 6
) (
    input wire               clk_in,
    input wire               rst_in,
    input wire               psel_in,
    input wire               penable_in,
    input wire               seq_stb_in,
    input wire [1:0]         seq_cmd_in,
    input wire [31:0]        prdata_out,
    input wire               pready_out,
    input wire               pslverr_out,
    input wire [NRAIL-1:0]   rail_en_out,
    input wire [NRAIL-1:0]   rail_pfm_out,
    input wire [NRAIL-1:0]   rail_ilim_out,
    input wire [NRAIL-1:0]   rail_pulldown_out,
    input wire [8*NRAIL-1:0] rail_vcode_out,
    input wire               feedback_port_one_out,
    input wire               slew_done_event_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    bus_answer_a: assert property (psel_in && !penable_in |=> pready_out && penable_in)
        else $error("Access phase got no ready.");
    bus_access_a: assert property (pready_out |-> psel_in && penable_in)
        else $error("Ready outside an access phase.");
    bus_err_a: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0000_0000)
        else $error("Error answer malformed.");
    pulldown_off_a: assert property ((rail_pulldown_out & rail_en_out) == '0)
        else $error("Pull-down on an enabled rail.");
    reset_off_a: assert property (seq_stb_in && seq_cmd_in == `BDVC_SEQ_RESET |-> ##2 rail_en_out == '0)
        else $error("Reset state left a rail on.");
    done_pulse_a: assert property (slew_done_event_out |=> !slew_done_event_out)
        else $error("Done event longer than a cycle.");
    done_quiet_a: assert property ($rose(slew_done_event_out) |-> !feedback_port_one_out)
        else $error("Done event while ready output high.");
    genvar i;
    for (i = 0; i < NRAIL; i = i + 1) begin : g_rail
        floor_pfm_a: assert property (
            (rail_en_out[i] && rail_vcode_out[8*i+:8] < `BDVC_VCODE_FLOOR) [*2] |-> rail_pfm_out[i])
            else $error("Rail below floor not in PFM.");
        soft_en_a: assert property ($rose(rail_ilim_out[i]) |-> rail_en_out[i])
            else $error("Current limit on a disabled rail.");
    end
endmodule
bind bdvc_buck_dvc_control bdvc_chk #(.NRAIL(NRAIL)) u_chk (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .seq_stb_in(seq_stb_in), .seq_cmd_in(seq_cmd_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .rail_en_out(rail_en_out),
    .rail_pfm_out(rail_pfm_out), .rail_ilim_out(rail_ilim_out), .rail_pulldown_out(rail_pulldown_out),
    .rail_vcode_out(rail_vcode_out), .feedback_port_one_out(feedback_port_one_out),
    .slew_done_event_out(slew_done_event_out));

// ==== buck_dvc_control_tb_top.sv ====
// Self-checking bench for the buck voltage-control block.
// Assumes the host model speaks APB; the bench drives pins and the sequencer strobe itself.
`timescale 1ns/1ns
`include "bdvc_map.vh"
module buck_dvc_control_tb_top;
    reg         clk_in, rst_in, stb, wake, seen;
    reg  [2:0]  gpi;
    reg  [1:0]  cmd;
    reg  [3:0]  slot;
    reg  [7:0]  v, x;
    wire        psel, pen, pwr, rdy, err, fb, done;
    wire [11:0] addr;
    wire [31:0] wd, rd;
    wire [5:0]  en, pfm, aut, ilim, pd;
    wire [47:0] code;
    integer     error_cnt, compares, seed, r, n;
    bdvc_buck_dvc_control #(.SOFT_CYC(50)) u_dut (
        .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(addr), .pwdata_in(wd), .prdata_out(rd), .pready_out(rdy), .pslverr_out(err),
        .gpi_in(gpi), .seq_stb_in(stb), .seq_cmd_in(cmd), .seq_slot_in(slot), .seq_wake_in(wake),
        .rail_en_out(en), .rail_pfm_out(pfm), .rail_auto_out(aut), .rail_ilim_out(ilim),
        .rail_pulldown_out(pd), .rail_vcode_out(code), .feedback_port_one_out(fb), .slew_done_event_out(done));
    bdvc_host u_host (.clk_in(clk_in), .psel_out(psel), .penable_out(pen), .pwrite_out(pwr),
        .paddr_out(addr), .pwdata_out(wd), .prdata_in(rd), .pready_in(rdy), .pslverr_in(err));
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    always @(posedge clk_in) if (done === 1'b1) seen <= 1'b1;
    function [11:0] ra(input integer i, input [11:0] s);
        ra = 12'(`BDVC_OFF_RAIL0 + `BDVC_RAIL_STRIDE * i + s);
    endfunction
    function [31:0] mode_exp(input [1:0] m);
        mode_exp = {30'h0, m == `BDVC_MODE_AUTO, m == `BDVC_MODE_PFM};
    endfunction
    task chk(input [8*8:1] nm, input [31:0] e, input [31:0] g);
        begin
            compares = compares + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task tick(input integer c);
        begin
            repeat (c) @(posedge clk_in);
            #1;
        end
    endtask
    task rdc(input [8*8:1] nm, input [11:0] a, input [31:0] e, input [31:0] m);
        begin
            u_host.xfer(1'b0, a, 32'h0000_0000);
            chk(nm, e, u_host.rd_q & m);
        end
    endtask
    task ramp(input integer i, input [7:0] e);
        begin
            for (n = 0; n < 45000 && code[8*i+:8] !== e; n = n + 1) @(posedge clk_in);
            chk("vcode", {24'h0, e}, {24'h0, code[8*i+:8]});
        end
    endtask
    task seq(input [1:0] c, input [3:0] s, input w);
        begin
            @(posedge clk_in);
            stb <= 1'b1;
            cmd <= c;
            slot <= s;
            wake <= w;
            @(posedge clk_in);
            stb <= 1'b0;
            wake <= 1'b0;
            tick(3);
        end
    endtask
    task end_of_test;
        begin
            $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
            if (error_cnt == 0 && compares > 0) begin
                $display("ALL TESTS PASSED");
            end else begin
                $display("TESTS FAILED");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (60000) @(posedge clk_in);
        error_cnt = error_cnt + 1;
        end_of_test;
    end
    initial begin
        {rst_in, stb, wake, seen, gpi, cmd, slot} = 13'h1000;
        error_cnt = 0;
        compares = 0;
        seed = 32'h083B;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        tick(1);
        chk("pulldown", 32'h3F, 32'(pd));
        rdc("vfirst", ra(0, `BDVC_SUB_VFIRST), `BDVC_VFIRST_RST, 32'hFF);
        for (r = 0; r < 6; r = r + 1) begin
            x = 8'h40 + 8'($random(seed) & 32'hF);
            u_host.xfer(1'b1, ra(r, `BDVC_SUB_VFIRST), {24'h0, x});
            rdc("vfirst", ra(r, `BDVC_SUB_VFIRST), {24'h0, x}, 32'hFF);
            if (r == 0) v = x;
        end
        rdc("resvd", `BDVC_OFF_SEQ, 32'h0, 32'hFFFF_FFFF);
        rdc("unmapped", 12'hFF0, 32'h0, 32'hFFFF_FFFF);
        chk("slverr", 32'h1, {31'h0, u_host.err_q});
        $display("register test done");
        // The global default-load bit stays clear; rails 0, 2 and 4 are enabled together by one group-select write.
        u_host.xfer(1'b1, `BDVC_OFF_CTRL, 32'h8);
        u_host.xfer(1'b1, `BDVC_OFF_SELG1, 32'h15);
        tick(1);
        chk("enable", 32'h15, 32'(en));
        chk("pulldown", 32'h2A, 32'(pd));
        u_host.xfer(1'b1, ra(1, `BDVC_SUB_CFG), 32'h10);
        tick(1);
        chk("pulldown", 32'h28, 32'(pd));
        ramp(0, v);
        x = v ^ 8'h08;
        u_host.xfer(1'b1, ra(0, `BDVC_SUB_VSECOND), {24'h0, x});
        tick(100);
        chk("hold", {24'h0, v}, {24'h0, code[7:0]});
        u_host.xfer(1'b1, `BDVC_OFF_SELG2, 32'h1);
        seen <= 1'b0;
        tick(3);
        chk("ready", 32'h1, {31'h0, fb});
        ramp(0, x);
        tick(10);
        chk("done", 32'h1, {31'h0, seen});
        u_host.xfer(1'b1, ra(0, `BDVC_SUB_VSECOND), 32'h20);
        for (n = 0; n < 45000 && pfm[0] !== 1'b1; n = n + 1) @(posedge clk_in);
        chk("pfm", 32'h1, {31'h0, pfm[0]});
        $display("ramp test done");
        for (r = 0; r < 3; r = r + 1) begin
            u_host.xfer(1'b1, ra(2, `BDVC_SUB_CFG), 32'(1 + 2 * r));
            tick(2);
            chk("mode", mode_exp(r), {30'h0, aut[2], pfm[2]});
        end
        u_host.xfer(1'b1, `BDVC_OFF_CTRL, 32'hC);
        u_host.xfer(1'b1, ra(3, `BDVC_SUB_CFG), 32'h1);
        tick(2);
        chk("ilim", 32'h1, {31'h0, ilim[3]});
        tick(60);
        chk("ilim", 32'h0, {31'h0, ilim[3]});
        // Fastest slew: two steps take between one and two 62-cycle tick periods plus output lag.
        u_host.xfer(1'b1, `BDVC_OFF_CTRL, 32'hB);
        u_host.xfer(1'b1, ra(3, `BDVC_SUB_VFIRST), 32'h50);
        ramp(3, 8'h50);
        u_host.xfer(1'b1, ra(3, `BDVC_SUB_VFIRST), 32'h52);
        for (n = 0; n < 1000 && code[31:24] !== 8'h52; n = n + 1) @(posedge clk_in);
        chk("slewfast", 32'h1, {31'h0, n >= 62 && n <= 127});
        $display("mode test done");
        u_host.xfer(1'b1, ra(4, `BDVC_SUB_CFG), 32'h0801);
        u_host.xfer(1'b1, ra(2, `BDVC_SUB_CFG), 32'h0809);
        u_host.xfer(1'b1, ra(1, `BDVC_SUB_CFG), 32'h0C50);
        u_host.xfer(1'b1, ra(5, `BDVC_SUB_CFG), 32'h0001);
        seq(`BDVC_SEQ_DOWN, 4'h2, 1'b0);
        chk("keep", 32'h04, 32'(en & 6'h14));
        rdc("select", `BDVC_OFF_SELG2, 32'h4, 32'h4);
        seq(`BDVC_SEQ_UP, 4'h2, 1'b1);
        rdc("select", `BDVC_OFF_SELG2, 32'h0, 32'h4);
        rdc("vfirst", ra(4, `BDVC_SUB_VFIRST), `BDVC_VFIRST_RST, 32'hFF);
        seq(`BDVC_SEQ_UP, 4'h0, 1'b0);
        chk("slotzero", 32'h0, 32'(en & 6'h29));
        $display("sequencer test done");
        @(posedge clk_in);
        gpi <= 3'h1;
        tick(3);
        chk("pin", 32'h1, {31'h0, en[1]});
        seq(`BDVC_SEQ_DOWN, 4'h3, 1'b0);
        chk("pin", 32'h1, {31'h0, en[1]});
        @(posedge clk_in);
        gpi <= 3'h0;
        tick(3);
        chk("pin", 32'h0, {31'h0, en[1]});
        seq(`BDVC_SEQ_RESET, 4'h0, 1'b0);
        chk("enable", 32'h0, 32'(en));
        chk("pulldown", 32'h3D, 32'(pd));
        $display("pin test done");
        end_of_test;
    end
endmodule
